// ==== core/alarm_channel.sv ====
// One threshold channel with delay filter and hysteresis release
`timescale 1ns/10ps
module alarm_channel
  import ins_alarm_pkg::*;
(
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // Inputs
  input  wire logic                       enable,
  input  wire logic                       sample_valid,
  input  wire logic [31:0]                sample_ohm,
  input  wire logic [31:0]                threshold,
  input  wire logic [15:0]                delay_s,
  input  wire logic                       tick,
  // Outputs
  output ins_alarm_pkg::alm_state_type    state,
  output logic                            rise_event
);
  import ins_alarm_pkg::*;

  alm_state_type state_q;         // Channel state
  logic [15:0]   count_q;         // Elapsed seconds in countdown
  logic          below;           // Sample under threshold
  logic          above_hys;       // Sample above release level

  // Release at 1.2 times threshold, compared without division
  function automatic logic over_hys(input logic [31:0] r, input logic [31:0] t);
    logic [35:0] lhs;
    logic [35:0] rhs;
    lhs = 36'(r) * 36'(HYS_DEN);
    rhs = 36'(t) * 36'(HYS_NUM);
    return lhs > rhs;
  endfunction

  assign below     = sample_ohm < threshold;
  assign above_hys = over_hys(sample_ohm, threshold);
  assign state     = state_q;

  // State and countdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= ALM_IDLE;
      count_q    <= 16'h0000;
      rise_event <= 1'b0;
    end else begin
      rise_event <= 1'b0;
      if (!enable) begin
        state_q <= ALM_IDLE;
        count_q <= 16'h0000;
      end else begin
        unique case (state_q)
          ALM_IDLE: begin
            if (sample_valid && below) begin
              count_q <= 16'h0000;
              if (delay_s == 16'h0000) begin
                state_q    <= ALM_ACTIVE;
                rise_event <= 1'b1;
              end else begin
                state_q <= ALM_COUNT;
              end
            end
          end
          ALM_COUNT: begin
            if (sample_valid && !below) begin
              state_q <= ALM_IDLE;
            end else if (tick) begin
              if (count_q + 16'h0001 >= delay_s) begin
                state_q    <= ALM_ACTIVE;
                rise_event <= 1'b1;
              end
              count_q <= count_q + 16'h0001;
            end
          end
          ALM_ACTIVE: begin
            if (sample_valid && above_hys) begin
              state_q <= ALM_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule

// ==== core/ins_alarm_eval.sv ====
// Insulation alarm evaluator top with APB registers, indicators and relays
//
// Overview of operation
// - Below preventive threshold: preventive relay and lamp
// - Fault persisting past delay: insulation alarm state
// - Acknowledge releases both relays when enabled
// - Fault cleared returns to normal status
// - Unacknowledged alarm cleared records transient fault
// - Transient only: status on, alarm flashing
// - Preventive plus transient: preventive on, flash
// - Active fault lights insulation alarm lamp, status and preventive lamps off
// - Inhibition flashes status, alarm lamps off
// - Bus activity flashes communication lamp
// - Inoperative: product lamp only, others off
// - Threshold ranges and defaults enforced
// - Thresholds held in retained storage
// - Below threshold: alarm now or countdown
// - Release only above 1.2 times threshold
// - Faults shorter than delay suppressed
// - Preventive delay hidden when preventive disabled
// - High resistance flags disconnection when enabled
// - Adaptor link loss always detected
// - Disconnection raises product status alarm
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module ins_alarm_eval
  import ins_alarm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P  = TICK_CYCLES,   // Cycles per second tick
  parameter int unsigned FLASH_CYCLES_P = FLASH_CYCLES   // Half period of flashing lamps
)(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Measurement front end
  input  wire logic        sample_valid,
  input  wire logic [31:0] sample_ohm,
  // Pins from outside
  input  wire logic        ack_button,
  input  wire logic        inhibit_in,
  input  wire logic        adaptor_link_ok,
  input  wire logic        self_test_fail,
  input  wire logic        serial_busy,
  // Relays
  output logic             ins_relay,
  output logic             pre_relay,
  // Indicators
  output logic             led_product,
  output logic             led_comm,
  output logic             led_status,
  output logic             led_pre,
  output logic             led_ins
);
  import ins_alarm_pkg::*;

  initial begin
    if (TICK_CYCLES_P < 2 || FLASH_CYCLES_P < 2) begin
      $error("tick and flash counts must be at least 2");
    end
  end

  // Settings, retained storage modelled by flip-flops
  logic [31:0]   ins_thr_q;       // Insulation threshold
  logic [31:0]   pre_thr_q;       // Preventive threshold or disabled
  logic [31:0]   disc_thr_q;      // Disconnection resistance limit
  logic [15:0]   ins_delay_q;     // fault_delay_setting
  logic [15:0]   pre_delay_q;     // early_warning_delay_setting
  logic          ack_en_q;        // Relays follow acknowledge
  logic          disc_en_q;       // Disconnect check enable
  // Alarm state
  logic          acked_q;         // Insulation alarm acknowledged
  logic          trans_q;         // Transient fault recorded
  logic          disc_q;          // Injection disconnection flagged
  logic [31:0]   last_r_q;        // Last sample seen
  // Time base
  logic [31:0]   tick_cnt_q;      // Second tick counter
  logic          tick_q;          // One second pulse
  logic [31:0]   flash_cnt_q;     // Flash half period counter
  logic          flash_q;         // Flash phase
  // Pin synchronisers, three stages
  logic [2:0]    ack_s_q;
  logic [2:0]    inh_s_q;
  logic [2:0]    link_s_q;
  logic [2:0]    fail_s_q;
  logic [2:0]    busy_s_q;
  logic          ack_lvl_q;       // Filtered levels
  logic          inh_lvl_q;
  logic          link_lvl_q;
  logic          fail_lvl_q;
  logic          busy_lvl_q;
  logic          ack_pulse;       // Button press edge
  // Channel results
  alm_state_type ins_state;
  alm_state_type pre_state;
  logic          ins_rise;
  logic          pre_enabled;
  logic          ins_active;
  logic          pre_active;
  logic          inoperative;
  // Bus decode
  logic          wr_en;
  logic          rd_en;
  logic          addr_ok;
  logic          sw_ack;
  logic          sw_clr_trans;

  // Filter a synchronised level: change when stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic cur);
    return (s[1] == s[2]) ? s[2] : cur;
  endfunction

  // Range check for a threshold write
  function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  assign pre_enabled  = pre_thr_q != PRE_THR_OFF;
  assign ins_active   = ins_state == ALM_ACTIVE;
  assign pre_active   = pre_state == ALM_ACTIVE;
  assign inoperative  = fail_lvl_q || disc_q;
  assign wr_en        = psel && penable && pwrite;
  assign rd_en        = psel && !penable && !pwrite;
  assign addr_ok      = (paddr[1:0] == 2'b00) && (paddr <= REG_DISC_THR);
  assign sw_ack       = wr_en && addr_ok && (paddr == REG_CTRL) && pwdata[CTRL_ACK];
  assign sw_clr_trans = wr_en && addr_ok && (paddr == REG_CTRL) && pwdata[CTRL_CLR_TRANS];
  assign ack_pulse    = (filt(ack_s_q, ack_lvl_q) && !ack_lvl_q) || sw_ack;

  // Insulation threshold channel
  alarm_channel u_ins (
    .pclk         (pclk),
    .presetn      (presetn),
    .enable       (!inh_lvl_q),
    .sample_valid (sample_valid),
    .sample_ohm   (sample_ohm),
    .threshold    (ins_thr_q),
    .delay_s      (ins_delay_q),
    .tick         (tick_q),
    .state        (ins_state),
    .rise_event   (ins_rise)
  );

  // Preventive threshold channel
  alarm_channel u_pre (
    .pclk         (pclk),
    .presetn      (presetn),
    .enable       (!inh_lvl_q && pre_enabled),
    .sample_valid (sample_valid),
    .sample_ohm   (sample_ohm),
    .threshold    (pre_thr_q),
    .delay_s      (pre_delay_q),
    .tick         (tick_q),
    .state        (pre_state),
    .rise_event   ()
  );

  // Pin synchronisers and filtered levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_s_q    <= 3'h0;
      inh_s_q    <= 3'h0;
      link_s_q   <= 3'h7;
      fail_s_q   <= 3'h0;
      busy_s_q   <= 3'h0;
      ack_lvl_q  <= 1'b0;
      inh_lvl_q  <= 1'b0;
      link_lvl_q <= 1'b1;
      fail_lvl_q <= 1'b0;
      busy_lvl_q <= 1'b0;
    end else begin
      ack_s_q    <= {ack_s_q[1:0], ack_button};
      inh_s_q    <= {inh_s_q[1:0], inhibit_in};
      link_s_q   <= {link_s_q[1:0], adaptor_link_ok};
      fail_s_q   <= {fail_s_q[1:0], self_test_fail};
      busy_s_q   <= {busy_s_q[1:0], serial_busy};
      ack_lvl_q  <= filt(ack_s_q, ack_lvl_q);
      inh_lvl_q  <= filt(inh_s_q, inh_lvl_q);
      link_lvl_q <= filt(link_s_q, link_lvl_q);
      fail_lvl_q <= filt(fail_s_q, fail_lvl_q);
      busy_lvl_q <= filt(busy_s_q, busy_lvl_q);
    end
  end

  // One second tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYCLES_P - 1)) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q     <= 1'b0;
    end
  end

  // Flash phase for blinking lamps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_q     <= 1'b0;
    end else if (flash_cnt_q == 32'(FLASH_CYCLES_P - 1)) begin
      flash_cnt_q <= 32'h0000_0000;
      flash_q     <= !flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
    end
  end

  // Settings written over APB, out-of-range values ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ins_thr_q   <= INS_THR_RST;
      pre_thr_q   <= PRE_THR_OFF;
      disc_thr_q  <= DISC_THR_RST;
      ins_delay_q <= DELAY_RST;
      pre_delay_q <= DELAY_RST;
      ack_en_q    <= 1'b1;
      disc_en_q   <= 1'b0;
    end else if (wr_en && addr_ok) begin
      unique case (paddr)
        REG_INS_THR: begin
          if (in_range(pwdata, INS_THR_MIN, INS_THR_MAX)) begin
            ins_thr_q <= pwdata;
          end
        end
        REG_PRE_THR: begin
          if (in_range(pwdata, PRE_THR_MIN, PRE_THR_MAX) || pwdata == PRE_THR_OFF) begin
            pre_thr_q <= pwdata;
          end
        end
        REG_DELAYS: begin
          if (pwdata[15:0] <= DELAY_MAX_S) begin
            ins_delay_q <= pwdata[15:0];
          end
          if (pwdata[31:16] <= DELAY_MAX_S) begin
            pre_delay_q <= pwdata[31:16];
          end
        end
        REG_CTRL: begin
          ack_en_q  <= pwdata[CTRL_ACK_EN];
          disc_en_q <= pwdata[CTRL_DISC_EN];
        end
        REG_DISC_THR: begin
          disc_thr_q <= pwdata;
        end
        default: begin
          ack_en_q <= ack_en_q;                  // Read-only locations
        end
      endcase
    end
  end

  // Acknowledge and transient fault recording
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acked_q <= 1'b0;
      trans_q <= 1'b0;
    end else begin
      if (ins_rise) begin
        acked_q <= 1'b0;
      end else if (ack_pulse && ins_active) begin
        acked_q <= 1'b1;
      end else if (!ins_active) begin
        acked_q <= 1'b0;
      end
      if (ins_active && !acked_q && sample_valid && sample_ohm >= ins_thr_q) begin
        trans_q <= 1'b1;
      end else if (sw_clr_trans || (ack_pulse && !ins_active)) begin
        trans_q <= 1'b0;
      end
    end
  end

  // Disconnection detection and last sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disc_q   <= 1'b0;
      last_r_q <= 32'h0000_0000;
    end else begin
      if (sample_valid) begin
        last_r_q <= sample_ohm;
      end
      if (!link_lvl_q) begin
        disc_q <= 1'b1;
      end else if (disc_en_q && sample_valid && sample_ohm > disc_thr_q) begin
        disc_q <= 1'b1;
      end else if (sample_valid && (sample_ohm <= disc_thr_q || !disc_en_q)) begin
        disc_q <= 1'b0;
      end
    end
  end

  // Relays, released on acknowledge when enabled
  // Inhibit gates them at once, as the channels only go idle one edge later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ins_relay <= 1'b0;
      pre_relay <= 1'b0;
    end else begin
      ins_relay <= ins_active && !inh_lvl_q && !(ack_en_q && acked_q);
      pre_relay <= (pre_active || ins_active) && !inh_lvl_q && !(ack_en_q && acked_q);
    end
  end

  // Indicator lamps, highest priority first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_product <= 1'b0;
      led_comm    <= 1'b0;
      led_status  <= 1'b0;
      led_pre     <= 1'b0;
      led_ins     <= 1'b0;
    end else begin
      led_comm <= busy_lvl_q && flash_q && !inoperative;
      if (inoperative) begin
        led_product <= 1'b1;
        led_status  <= 1'b0;
        led_pre     <= 1'b0;
        led_ins     <= 1'b0;
      end else if (inh_lvl_q) begin
        led_product <= 1'b0;
        led_status  <= flash_q;
        led_pre     <= 1'b0;
        led_ins     <= 1'b0;
      end else if (ins_active) begin
        led_product <= 1'b0;
        led_status  <= 1'b0;
        led_pre     <= 1'b0;
        led_ins     <= 1'b1;
      end else if (pre_active) begin
        led_product <= 1'b0;
        led_status  <= 1'b0;
        led_pre     <= 1'b1;
        led_ins     <= trans_q && flash_q;
      end else begin
        led_product <= 1'b0;
        led_status  <= 1'b1;
        led_pre     <= 1'b0;
        led_ins     <= trans_q && flash_q;
      end
    end
  end

  // APB read data and answer, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        unique case (paddr)
          REG_INS_THR:  prdata <= ins_thr_q;
          REG_PRE_THR:  prdata <= pre_thr_q;
          REG_DELAYS:   prdata <= {(pre_enabled ? pre_delay_q : 16'h0000), ins_delay_q};
          REG_CTRL:     prdata <= {30'h0000_0000, disc_en_q, ack_en_q};
          REG_STATUS:   prdata <= {22'h00_0000, ins_state, 2'h0, inoperative, disc_q,
                                   trans_q, acked_q, ins_active, pre_active};
          REG_LAST_R:   prdata <= last_r_q;
          REG_DISC_THR: prdata <= disc_thr_q;
          default:      prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ==== core/ins_alarm_pkg.sv ====
// Package with constants, register map and types for the insulation alarm evaluator
package ins_alarm_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ          = 200_000_000;             // System clock rate
  localparam int unsigned TICK_S          = 1;                       // Delay tick period in seconds
  localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_S;         // Cycles per delay tick
  localparam int unsigned FLASH_S_DIV     = 2;                       // Flash phase toggles four times a second
  localparam int unsigned FLASH_CYCLES    = CLK_HZ / (2 * FLASH_S_DIV); // Half period of flash
  // Resistance values in ohms, 32 bits
  localparam logic [31:0] INS_THR_MIN     = 32'h0000_0028;           // 40 ohm lower limit
  localparam logic [31:0] INS_THR_MAX     = 32'h0007_A120;           // 500 kilohm upper limit
  localparam logic [31:0] INS_THR_RST     = 32'h0000_03E8;           // 1 kilohm default
  localparam logic [31:0] PRE_THR_MIN     = 32'h0000_03E8;           // 1 kilohm
  localparam logic [31:0] PRE_THR_MAX     = 32'h000F_4240;           // 1 megohm
  localparam logic [31:0] PRE_THR_OFF     = 32'hFFFF_FFFF;           // Disabled code
  localparam logic [31:0] DISC_THR_RST    = 32'h0FFF_FFFF;           // High resistance limit default
  // Delay range in seconds
  localparam int unsigned DELAY_MAX_MIN   = 120;                     // Longest delay in minutes
  localparam logic [15:0] DELAY_MAX_S     = 16'(DELAY_MAX_MIN * 60); // Longest delay in seconds
  localparam logic [15:0] DELAY_RST       = 16'h0000;                // Default delay
  // Hysteresis ratio 12/10
  localparam logic [3:0]  HYS_NUM         = 4'hC;
  localparam logic [3:0]  HYS_DEN         = 4'hA;
  // Register byte offsets
  localparam logic [11:0] REG_INS_THR     = 12'h000;
  localparam logic [11:0] REG_PRE_THR     = 12'h004;
  localparam logic [11:0] REG_DELAYS      = 12'h008;
  localparam logic [11:0] REG_CTRL        = 12'h00C;
  localparam logic [11:0] REG_STATUS      = 12'h010;
  localparam logic [11:0] REG_LAST_R      = 12'h014;
  localparam logic [11:0] REG_DISC_THR    = 12'h018;
  // Control field positions
  localparam int unsigned CTRL_ACK_EN     = 0;                       // Relays follow acknowledge
  localparam int unsigned CTRL_DISC_EN    = 1;                       // Disconnect check enable
  localparam int unsigned CTRL_ACK        = 2;                       // Write one acknowledges
  localparam int unsigned CTRL_CLR_TRANS  = 3;                       // Write one clears transient
  // Status field positions
  localparam int unsigned ST_PRE          = 0;
  localparam int unsigned ST_INS          = 1;
  localparam int unsigned ST_ACKED        = 2;
  localparam int unsigned ST_TRANS        = 3;
  localparam int unsigned ST_DISC         = 4;
  localparam int unsigned ST_PRODUCT      = 5;
  localparam int unsigned ST_STATE_LSB    = 8;
  // Alarm state encoding
  typedef enum logic [1:0] {
    ALM_IDLE,
    ALM_COUNT,
    ALM_ACTIVE
  } alm_state_type;
endpackage

// ==== testbench/front_end_model.sv ====
// Measurement front end model sending a sample every eight cycles
`timescale 1ns/10ps
module front_end_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Resistance to report
  input  wire logic [31:0] level,
  // Sample stream
  output logic             sample_valid,
  output logic [31:0]      sample_ohm
);
  logic [2:0] cnt_q; // Sample spacing
  // Strobe once per eight cycles, data scrambled between strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q        <= 3'h0;
      sample_valid <= 1'b0;
      sample_ohm   <= 32'h0;
    end else begin
      cnt_q        <= cnt_q + 3'h1;
      sample_valid <= (cnt_q == 3'h7);
      sample_ohm   <= (cnt_q == 3'h7) ? level : ~sample_ohm;
    end
  end
endmodule

// ==== testbench/ins_alarm_eval_sva.sv ====
// Checker of lamp, relay and bus timing at the evaluator ports
`timescale 1ns/10ps
module ins_alarm_sva #(
  parameter int unsigned TICK_CYCLES_P  = 20,
  parameter int unsigned FLASH_CYCLES_P = 4
)(
  // Watched ports
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic inhibit_in,
  input wire logic self_test_fail,
  input wire logic ins_relay,
  input wire logic pre_relay,
  input wire logic led_product,
  input wire logic led_comm,
  input wire logic led_status,
  input wire logic led_pre,
  input wire logic led_ins
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pre_follows_a: assert property (ins_relay |-> pre_relay)
    else $error("pre relay low during alarm");
  ins_lamps_a: assert property (ins_relay && !led_product |-> led_ins && !led_pre && !led_status)
    else $error("alarm lamps wrong");
  pre_lamps_a: assert property (pre_relay && !ins_relay && !led_product |-> led_pre && !led_status)
    else $error("early lamps wrong");
  product_lamps_a: assert property (led_product |-> !(led_comm || led_status || led_pre || led_ins))
    else $error("lamps lit while inoperative");
  inhibit_dark_a: assert property (inhibit_in [*8] |=> !led_pre && !led_ins && !ins_relay)
    else $error("alarm shown while inhibited");
  selftest_lamp_a: assert property (self_test_fail [*8] |=> led_product)
    else $error("product lamp not lit");
  bus_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  cover property ($rose(ins_relay));
  cover property ($rose(led_product));
  cover property ($fell(pre_relay) && !ins_relay);
endmodule
bind ins_alarm_eval ins_alarm_sva #(.TICK_CYCLES_P(TICK_CYCLES_P), .FLASH_CYCLES_P(FLASH_CYCLES_P)) i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .inhibit_in(inhibit_in),
  .self_test_fail(self_test_fail), .ins_relay(ins_relay), .pre_relay(pre_relay), .led_product(led_product),
  .led_comm(led_comm), .led_status(led_status), .led_pre(led_pre), .led_ins(led_ins));

// ==== testbench/tb.sv ====
// Self-checking bench of the insulation alarm evaluator
`timescale 1ns/10ps
module tb;
  import ins_alarm_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, ohm = 32'h9C4, sohm, r;
  logic        sv, pready, pslverr, ack_button = 0, inhibit_in = 0, adaptor_link_ok = 1;
  logic        self_test_fail = 0, serial_busy = 0, ins_relay, pre_relay;
  logic        led_product, led_comm, led_status, led_pre, led_ins, ins_l, com_l;
  int          errors = 0, samples_checked = 0, cyc = 0, ins_fl, comm_fl;
  always #2.5 pclk = ~pclk;
  front_end_model i_front_end_model (.pclk(pclk), .presetn(presetn), .level(ohm), .sample_valid(sv),
    .sample_ohm(sohm));
  ins_alarm_eval #(.TICK_CYCLES_P(20), .FLASH_CYCLES_P(4)) i_ins_alarm_eval (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sv), .sample_ohm(sohm), .ack_button(ack_button),
    .inhibit_in(inhibit_in), .adaptor_link_ok(adaptor_link_ok), .self_test_fail(self_test_fail),
    .serial_busy(serial_busy), .ins_relay(ins_relay), .pre_relay(pre_relay), .led_product(led_product),
    .led_comm(led_comm), .led_status(led_status), .led_pre(led_pre), .led_ins(led_ins));
  // Lamp toggle counters and hang limit
  always @(posedge pclk) begin
    ins_fl += int'(led_ins !== ins_l);
    comm_fl += int'(led_comm !== com_l);
    ins_l = led_ins;
    com_l = led_comm;
    if (++cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic t_regs();
    apb(0, REG_INS_THR, 0); chk(r, INS_THR_RST);
    apb(1, REG_DELAYS, 32'h0005_0000); apb(0, REG_DELAYS, 0); chk(r, 32'h0);
    apb(1, REG_DELAYS, 32'h0); apb(1, REG_PRE_THR, 32'h0020_0000);
    apb(0, REG_PRE_THR, 0); chk(r, PRE_THR_OFF);
    apb(0, 12'h01C, 0); chk(32'(perr), 32'h1);
    chk(32'(led_status), 32'h1);
    $display("regs done");
  endtask
  task automatic t_pre();
    apb(1, REG_PRE_THR, 32'h7D0); ohm <= 32'h5DC; wt(30);
    chk({pre_relay, led_pre, ins_relay}, 3'b110);
    ohm <= 32'h8FC; wt(30); chk(32'(pre_relay), 32'h1);
    ohm <= 32'h9C4; wt(30); chk({pre_relay, led_status}, 2'b01);
    $display("pre done");
  endtask
  task automatic t_ins();
    apb(1, REG_DELAYS, 32'h3); ohm <= 32'h1F4; wt(40); ohm <= 32'h9C4; wt(30);
    chk(32'(ins_relay), 32'h0);
    ohm <= 32'h1F4; wt(100); chk(32'(ins_relay), 32'h1);
    chk({led_ins, led_pre, led_status, led_product}, 4'b1000);
    ack_button <= 1; wt(10); ack_button <= 0; wt(10); chk({ins_relay, pre_relay}, 2'b00);
    ohm <= 32'h9C4; wt(30); chk(32'(led_status), 32'h1);
    apb(0, REG_STATUS, 0); chk(32'(r[ST_TRANS]), 32'h0);
    $display("ins done");
  endtask
  task automatic t_trans();
    apb(1, REG_DELAYS, 32'h0); ohm <= 32'h1F4; wt(30); chk(32'(ins_relay), 32'h1);
    ohm <= 32'h9C4; wt(30); apb(0, REG_STATUS, 0); chk(32'(r[ST_TRANS]), 32'h1);
    ins_fl = 0; wt(16); chk({led_status, led_pre, ins_fl > 1}, 3'b101);
    ohm <= 32'h5DC; wt(30); ins_fl = 0; wt(16);
    chk({led_pre, led_status, ins_fl > 1}, 3'b101);
    apb(1, REG_CTRL, 32'h9); ohm <= 32'h9C4; wt(30);
    apb(0, REG_STATUS, 0); chk(32'(r[ST_TRANS]), 32'h0);
    $display("transient done");
  endtask
  task automatic t_pins();
    inhibit_in <= 1; ohm <= 32'h1F4; wt(30); chk({ins_relay, led_ins, led_pre}, 3'b000);
    inhibit_in <= 0; ohm <= 32'h9C4; wt(30);
    self_test_fail <= 1; wt(20); chk({led_product, led_status}, 2'b10);
    self_test_fail <= 0; adaptor_link_ok <= 0; wt(20); chk(32'(led_product), 32'h1);
    adaptor_link_ok <= 1; apb(1, REG_DISC_THR, 32'h0001_0000); apb(1, REG_CTRL, 32'h3);
    ohm <= 32'h0002_0000; wt(30); chk(32'(led_product), 32'h1);
    ohm <= 32'h9C4; wt(30); chk(32'(led_product), 32'h0);
    serial_busy <= 1; comm_fl = 0; wt(30); chk(32'(comm_fl > 1), 32'h1);
    serial_busy <= 0;
    $display("pins done");
  endtask
  // Main sequence
  initial begin
    wt(16);
    presetn <= 1;
    wt(4);
    t_regs();
    t_pre();
    t_ins();
    t_trans();
    t_pins();
    summarize();
  end
endmodule
